// ### rtl/cfg_loader.sv
// power-up serial configuration loader: one write master, then halt
// assumes open-drain pads with pull-ups; oe high pulls the line low
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"
module cfg_loader #(
  parameter int unsigned START_DELAY = `START_DELAY_CYC,
  parameter int unsigned QTR = `QTR_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic busy,
  output logic done
);
  // table lookup: each run opens with slave byte then subaddress
  function automatic cfg_loader_pkg::entry_t tbl(input logic [5:0] i);
    unique case (i)
      6'd0: tbl = '{1'b1, `SLV_DEC};
      6'd1: tbl = '{1'b0, 8'h00};
      6'd2: tbl = '{1'b0, 8'h64};
      6'd3: tbl = '{1'b0, 8'h35};
      6'd4: tbl = '{1'b0, 8'h0a};
      6'd5: tbl = '{1'b0, 8'hf8};
      6'd6: tbl = '{1'b0, 8'hca};
      6'd7: tbl = '{1'b0, 8'hfe};
      6'd8: tbl = '{1'b0, 8'h29};
      6'd9: tbl = '{1'b0, 8'h00};
      6'd10: tbl = '{1'b0, 8'h77};
      6'd11: tbl = '{1'b0, 8'he0};
      6'd12: tbl = '{1'b0, 8'h40};
      6'd13: tbl = '{1'b0, 8'h00};
      6'd14: tbl = '{1'b1, `SLV_BIAS};
      6'd15: tbl = '{1'b0, 8'h00};
      6'd16: tbl = '{1'b0, 8'h26};
      6'd17: tbl = '{1'b0, 8'h26};
      6'd18: tbl = '{1'b0, `BIAS_B2};
      6'd19: tbl = '{1'b0, 8'h00};
      6'd20: tbl = '{1'b0, 8'h00};
      6'd21: tbl = '{1'b0, 8'h23};
      6'd22: tbl = '{1'b0, `BIAS_B6};
      6'd23: tbl = '{1'b0, 8'h3f};
      6'd24: tbl = '{1'b1, `SLV_RGB};
      6'd25: tbl = '{1'b0, 8'h00};
      6'd26: tbl = '{1'b0, `RGB_B0};
      6'd27: tbl = '{1'b0, 8'h13};
      6'd28: tbl = '{1'b0, 8'h33};
      6'd29: tbl = '{1'b0, 8'h22};
      6'd30: tbl = '{1'b0, 8'h34};
      6'd31: tbl = '{1'b0, 8'h34};
      6'd32: tbl = '{1'b0, 8'h34};
      6'd33: tbl = '{1'b0, 8'h20};
      6'd34: tbl = '{1'b0, 8'h20};
      6'd35: tbl = '{1'b0, 8'h20};
      6'd36: tbl = '{1'b0, 8'h3f};
      // 0b skipped: fresh transaction at 0c
      6'd37: tbl = '{1'b1, `SLV_RGB};
      6'd38: tbl = '{1'b0, 8'h0c};
      6'd39: tbl = '{1'b0, 8'h89};
      6'd40: tbl = '{1'b0, 8'h10};
      default: tbl = '{1'b1, 8'h00};
    endcase
  endfunction

  localparam logic [5:0] LAST = 6'(`TBL_LEN - 1);

  cfg_loader_pkg::state_t st_q;
  logic [31:0] wait_q;
  logic [15:0] tq_q;
  logic [1:0] ph_q;
  logic [2:0] bit_q;
  logic [5:0] idx_q;
  logic [7:0] sh_q;
  logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
  logic tick;
  cfg_loader_pkg::entry_t cur_e;
  cfg_loader_pkg::entry_t nxt_e;

  // current and following entry; the lookahead tells where a run ends
  assign cur_e = tbl(idx_q);
  assign nxt_e = tbl(idx_q + 6'd1);

  // pad inputs synchronised; the synchronised values are never read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
    end
  end

  // quarter-bit timebase, free running while active
  assign tick = (tq_q == 16'(QTR - 1));
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      tq_q <= '0;
    else if (tick || st_q == cfg_loader_pkg::ST_WAIT || st_q == cfg_loader_pkg::ST_HALT)
      tq_q <= '0;
    else
      tq_q <= tq_q + 16'd1;
  end

  // main sequence; no arbitration, the other master stays off the bus
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= cfg_loader_pkg::ST_WAIT;
      wait_q <= '0;
      ph_q <= '0;
      bit_q <= '0;
      idx_q <= '0;
      sh_q <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      unique case (st_q)
        cfg_loader_pkg::ST_WAIT: begin
          // power-up delay, then start unprompted
          if (wait_q == START_DELAY - 1) begin
            st_q <= cfg_loader_pkg::ST_START;
            busy <= 1'b1;
            ph_q <= '0;
          end else
            wait_q <= wait_q + 32'd1;
        end
        cfg_loader_pkg::ST_START: if (tick) begin
          // sda falls while scl high, then scl low
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd1)
            sda_oe <= 1'b1;
          if (ph_q == 2'd2)
            scl_oe <= 1'b1;
          if (ph_q == 2'd3) begin
            sh_q <= cur_e.data;
            bit_q <= 3'd7;
            st_q <= cfg_loader_pkg::ST_BITS;
          end
        end
        cfg_loader_pkg::ST_BITS: if (tick) begin
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_oe <= ~sh_q[7];
            2'd1: scl_oe <= 1'b0;
            2'd2: ;
            2'd3: begin
              scl_oe <= 1'b1;
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q - 3'd1;
              if (bit_q == 3'd0)
                st_q <= cfg_loader_pkg::ST_ACK;
            end
          endcase
        end
        cfg_loader_pkg::ST_ACK: if (tick) begin
          // acknowledge clocked but not checked: fixed board, no retry
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_oe <= 1'b0;
            2'd1: scl_oe <= 1'b0;
            2'd2: ;
            2'd3: begin
              scl_oe <= 1'b1;
              if (idx_q == LAST || nxt_e.first)
                st_q <= cfg_loader_pkg::ST_STOP;
              else begin
                idx_q <= idx_q + 6'd1;
                sh_q <= nxt_e.data;
                bit_q <= 3'd7;
                st_q <= cfg_loader_pkg::ST_BITS;
              end
            end
          endcase
        end
        cfg_loader_pkg::ST_STOP: if (tick) begin
          // sda rises while scl high
          ph_q <= ph_q + 2'd1;
          unique case (ph_q)
            2'd0: sda_oe <= 1'b1;
            2'd1: scl_oe <= 1'b0;
            2'd2: sda_oe <= 1'b0;
            2'd3: begin
              if (idx_q == LAST) begin
                st_q <= cfg_loader_pkg::ST_HALT;
                busy <= 1'b0;
                done <= 1'b1;
              end else begin
                idx_q <= idx_q + 6'd1;
                st_q <= cfg_loader_pkg::ST_START;
              end
            end
          endcase
        end
        cfg_loader_pkg::ST_HALT: begin
          // lines released for good; external master may take over
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pull low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end
endmodule

// ### rtl/cfg_loader_defines.svh
// constants for the power-up configuration loader: table, timing, bus timing
// assumes the loader runs from a single 25 MHz controller clock
//
// Behaviour
// - after power-up the loader writes the whole fixed table to all three slaves with no request from anyone.
// - the decoder at slave byte 8a gets twelve bytes from subaddress 00: 64 35 0a f8 ca fe 29 00 77 e0 40 00.
// - the bias device at slave byte 40 gets eight bytes from subaddress 00: 26 26 1? 00 00 23 3? 3f.
// - the rgb processor at slave byte 88 gets 2? 13 33 22 34 34 34 20 20 20 at 00-09, then 3f at 0a, 89 at 0c, 10 at 0d.
// - subaddress 0b of the rgb processor is never written, so the sequence jumps from 0a to 0c.
// - sending starts about one second after power-up and the loader halts inactive once done.
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH

`define CLK_HZ 25000000
`define START_DELAY_MS 1000
// cycles before the first start condition
`define START_DELAY_CYC ((`CLK_HZ / 1000) * `START_DELAY_MS)
// quarter period of a 100 kHz serial clock
`define SCL_HZ 100000
`define QTR_CYC (`CLK_HZ / (4 * `SCL_HZ))

// table of bytes; a flag bit marks the first byte of each transaction
// entries in the table, slave bytes and subaddresses included
`define TBL_LEN 41
`define SLV_DEC 8'h8a
`define SLV_BIAS 8'h40
`define SLV_RGB 8'h88
// illegible second digits: taken as zero
`define BIAS_B2 8'h10
`define BIAS_B6 8'h30
`define RGB_B0 8'h20

`endif

// ### rtl/cfg_loader_pkg.sv
// types for the power-up configuration loader
// assumes cfg_loader_defines.svh supplies the numbers
package cfg_loader_pkg;
  typedef enum logic [2:0] {
    ST_WAIT, ST_START, ST_BITS, ST_ACK, ST_STOP, ST_HALT
  } state_t;
  // one table entry: byte plus opening-a-transaction flag
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } entry_t;
  // open-drain pin drive toward the pad
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } pin_drv_t;
endpackage

// ### tb/cfg_loader_checker.sv
// checker for the configuration loader, bound to its ports
// assumes small START_DELAY and QTR of 2 to 8 in simulation
`timescale 1ns/1ps
module cfg_loader_checker #(
  parameter int unsigned START_DELAY = 50,
  parameter int unsigned QTR = 2
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic busy,
  input wire logic done
);
  int unsigned cyc_q;
  // edges since release; saturates so a long run cannot wrap
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      cyc_q <= 0;
    else if (cyc_q != 32'hffffffff)
      cyc_q <= cyc_q + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_pull;
    ##[0:7] scl_oe;
  endsequence
  property p_start; s_start |=> s_pull; endproperty
  property p_delay; $rose(busy) |-> cyc_q == START_DELAY; endproperty
  property p_tick; $changed(scl_oe) |=> $stable(scl_oe); endproperty
  property p_busy_hold; $rose(busy) |-> busy [*8]; endproperty
  property p_done_sticky; done |=> done; endproperty
  property p_halt_quiet; done |-> !busy && !scl_oe && !sda_oe; endproperty
  property p_idle; !busy |-> !scl_oe && !sda_oe; endproperty
  property p_fell_done; $fell(busy) |-> done; endproperty
  a_start: assert property (p_start) else $error("start not followed by clock low");
  a_delay: assert property (p_delay) else $error("busy rose at wrong cycle");
  a_tick: assert property (p_tick) else $error("clock changed on adjacent cycles");
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  a_done_sticky: assert property (p_done_sticky) else $error("done fell");
  a_halt_quiet: assert property (p_halt_quiet) else $error("active after done");
  a_idle: assert property (p_idle) else $error("line driven while idle");
  a_fell_done: assert property (p_fell_done) else $error("busy fell without done");
endmodule

bind cfg_loader cfg_loader_checker #(.START_DELAY(START_DELAY), .QTR(QTR)) chk_u (.mclk(mclk), .rst_b(rst_b),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy),
  .done(done));

// ### tb/cfg_loader_tb.sv
// bench for the configuration loader against the slave model
// assumes short delay and quarter-bit parameters
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"
module cfg_loader_tb;
  localparam int SD = 50;
  localparam int NB = 41;
  localparam logic [8*NB-1:0] EXP = {`SLV_DEC, 8'h00, 8'h64, 8'h35, 8'h0a, 8'hf8, 8'hca, 8'hfe, 8'h29, 8'h00,
    8'h77, 8'he0, 8'h40, 8'h00, `SLV_BIAS, 8'h00, 8'h26, 8'h26, `BIAS_B2, 8'h00, 8'h00, 8'h23, `BIAS_B6, 8'h3f,
    `SLV_RGB, 8'h00, `RGB_B0, 8'h13, 8'h33, 8'h22, 8'h34, 8'h34, 8'h34, 8'h20, 8'h20, 8'h20, 8'h3f,
    `SLV_RGB, 8'h0c, 8'h89, 8'h10};
  logic mclk, rst_b, clr, scl_oe, sda_oe, scl_o, sda_o, busy, done, ack_oe;
  cfg_loader_pkg::entry_t got [0:63];
  int n_got, n_stop, num_errors, checked;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || ack_oe);
  cfg_loader #(.START_DELAY(SD), .QTR(2)) dut_u (.mclk(mclk), .rst_b(rst_b), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy), .done(done));
  cfg_slaves slv_u (.scl(scl), .sda(sda), .clr(clr), .ack_oe(ack_oe), .got(got), .n_got(n_got), .n_stop(n_stop));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = !mclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
    checked++;
    if (act !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge mclk) rst_b = 1'b0;
    clr = 1'b1;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    clr = 1'b0;
  endtask
  // quiet through the start delay, then busy
  task automatic t_idle;
    repeat (SD - 1) @(negedge mclk) chk("idle", 3'b000, {busy, scl_oe, sda_oe});
    @(negedge mclk) chk("busy", 3'b100, {busy, scl_oe, sda_oe});
  endtask
  // whole table, in order, four transactions, 0b never written
  task automatic t_seq;
    int i;
    for (i = 0; i < 20000 && done !== 1'b1; i++)
      @(negedge mclk);
    if (i == 20000) begin
      num_errors++;
      give_verdict;
    end
    chk("count", NB, n_got);
    chk("stops", 4, n_stop);
    for (i = 0; i < NB; i++) begin
      chk("byte", EXP[8*(NB-1-i) +: 8], got[i].data);
      chk("first", i == 0 || i == 14 || i == 24 || i == 37, got[i].first);
    end
  endtask
  // halted: lines free, done held
  task automatic t_halt;
    repeat (20) begin
      repeat (10) @(negedge mclk);
      chk("halt", 4'b0001, {busy, scl_oe, sda_oe, done});
      chk("pads", 2'b00, {scl_o, sda_o});
    end
  endtask
  // reset in mid-table restarts the whole load
  task automatic t_mid_reset;
    do_reset;
    repeat (SD + 120) @(negedge mclk);
    rst_b = 1'b0;
    clr = 1'b1;
    @(negedge mclk) chk("in reset", 4'b0000, {busy, scl_oe, sda_oe, done});
    rst_b = 1'b1;
    clr = 1'b0;
  endtask
  initial begin
    rst_b = 1'b0;
    clr = 1'b0;
    num_errors = 0;
    checked = 0;
    do_reset;
    t_idle;
    t_seq;
    t_halt;
    t_mid_reset;
    t_seq;
    give_verdict;
  end
endmodule

// ### tb/cfg_slaves.sv
// three serial slaves in one: acks and logs each byte, up to 64 bytes
// assumes pulled-up lines worked out by the bench
`timescale 1ns/1ps
module cfg_slaves (
  input wire logic scl,
  input wire logic sda,
  input wire logic clr,
  output logic ack_oe,
  output cfg_loader_pkg::entry_t got [0:63],
  output int n_got,
  output int n_stop
);
  logic [7:0] sh;
  int bits;
  logic fst;
  // ack let go as reset starts; lines jump high then, so a false stop may be seen
  always @(posedge clr)
    ack_oe = 1'b0;
  // log cleared only at release, after any such false stop
  always @(negedge clr) begin
    n_got = 0;
    n_stop = 0;
    bits = 0;
  end
  // start and stop are data edges while clock is high
  always @(negedge sda) if (scl) begin
    bits = 0;
    fst = 1'b1;
  end
  always @(posedge sda) if (scl)
    n_stop = n_stop + 1;
  always @(posedge scl) begin
    if (bits < 8)
      sh = {sh[6:0], sda};
    bits = bits + 1;
  end
  // only pulls data for ack, never holds clock
  always @(negedge scl) begin
    if (bits == 8 && n_got < 64) begin
      got[n_got] = '{first: fst, data: sh};
      n_got = n_got + 1;
      fst = 1'b0;
      ack_oe = 1'b1;
    end else if (bits == 9) begin
      ack_oe = 1'b0;
      bits = 0;
    end
  end
endmodule
